/* spm_pkg.sv */
// constants for the serial peripheral port
package spm_pkg;
   // register indices; byte address is four times the index
   localparam logic [9:0] STAT_IDX = 10'h0E1;
   localparam logic [9:0] CTRL_IDX = 10'h0E2;
   localparam logic [9:0] DATA_IDX = 10'h0E3;
   localparam logic [9:0] CFG_IDX  = 10'h0E4;
   localparam logic [9:0] MASK_IDX = 10'h0E5;
   // control fields
   localparam int CTRL_SELECT_IGNORE_BIT = 7;
   localparam int CTRL_EN   = 6;
   localparam int CTRL_ORD  = 5;
   localparam int CTRL_MASTER_SELECT_BIT = 4;
   localparam int CTRL_CPOL = 3;
   localparam int CTRL_CPHA = 2;
   localparam int CTRL_RATE = 0;
   localparam logic [7:0] CTRL_RST = 8'h04;
   // status and mask fields
   localparam int STAT_DONE = 7;
   localparam int STAT_WRITE_COLLISION_FLAG = 6;
   // config fields
   localparam int CFG_SELOUT = 0;
   localparam int CFG_PIE    = 1;
   localparam int CFG_GIE    = 2;
   localparam logic [2:0] CFG_RST = 3'h0;
   // clock divisors per rate code
   localparam int DIV_R0 = 4;
   localparam int DIV_R1 = 16;
   localparam int DIV_R2 = 64;
   localparam int DIV_R3 = 128;
   // link rate ceiling and the core clock
   localparam int CLK_KHZ      = 40000;
   localparam int LINK_MAX_KBPS = 3000;
   // least core cycles per serial half bit at the ceiling
   localparam int LINK_MIN_HALF =
      (CLK_KHZ + 2 * LINK_MAX_KBPS - 1) / (2 * LINK_MAX_KBPS);
   localparam logic [3:0] LAST_EDGE = 4'hF;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_XFER = 2'b10
   } spm_state_t;
endpackage : spm_pkg

/* spm_port.sv */
// serial peripheral port, master or slave, with an apb register file
//
// Design decision made here: register access over APB.
`timescale 1ns/1ps
// Behaviour
// - The port exchanges data both ways at once and acts as master or slave.
// - The link runs at up to 10 Mbit/s as master (core clock over 4) and up to 3 Mbit/s as slave.
// - Master-to-slave data goes on mosi and slave-to-master data on miso.
// - The serial clock pin is driven as master and only read as slave.
// - With the port disabled (the reset state) no serial pin is driven.
// - A slave takes part in a transfer only while its select input is low or select-ignore is set.
// - The select input is ignored while the port is disabled.
// - The select input is ignored as master with the select pin an output.
// - With select-ignore set the role comes from master-select alone.
// - A low select on a master with select input live turns it slave.
// - Control holds ignore, enable, order, master, polarity, phase, rate.
// - The master clock divides the core clock by 4, 16, 64 or 128.
// - Polarity sets the idle level and phase picks the sampling edge.
// - Order set sends the lsb first, clear sends the msb first.
// - A data write mid-transfer flags a collision; flags clear by a one.
module spm_port (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        sck_i,
   output logic             sck_o,
   output logic             sck_oe,
   input  wire logic        mosi_i,
   output logic             mosi_o,
   output logic             mosi_oe,
   input  wire logic        miso_i,
   output logic             miso_o,
   output logic             miso_oe,
   input  wire logic        ss_n_i,
   output logic             ss_pin_port,
   output logic             irq
);
   function automatic logic hit(input logic [11:0] a,
                                input logic [9:0]  idx);
      return a[11:2] == idx;
   endfunction : hit

   function automatic logic [6:0] half_of(input logic [1:0] r);
      unique case (r)
         2'h0: return 7'(spm_pkg::DIV_R0 / 2);
         2'h1: return 7'(spm_pkg::DIV_R1 / 2);
         2'h2: return 7'(spm_pkg::DIV_R2 / 2);
         2'h3: return 7'(spm_pkg::DIV_R3 / 2);
      endcase
   endfunction : half_of

   logic [7:0]         ctrl, next_ctrl;
   logic [2:0]         cfg, next_cfg;
   logic [1:0]         mask, next_mask;
   logic               done, next_done;
   logic               write_collision_flag, next_write_collision_flag;
   logic [31:0]        next_prdata;
   logic               next_pready, next_pslverr, next_irq;
   spm_pkg::spm_state_t state, next_state;
   logic [7:0]         sh, next_sh;
   logic [6:0]         cnt, next_cnt;
   logic [3:0]         ecnt, next_ecnt;
   logic               dout, next_dout;
   logic               sck_prev;
   logic               next_sck, next_sck_oe, next_mosi_oe;
   logic               next_miso_oe, next_ss_pin_port;

   logic en, select_ignore_bit, ord, master_select_bit, cpol, cpha, selout;
   logic req, acc, wr, wr_ctrl, wr_data, wr_stat, mapped;
   logic fault, is_master, slv_sel, busy;
   logic tick, m_lead, m_trail, s_edge, lead, trail;
   logic samp, drv, inb, edge_ev;

   // ---------------- register bus ----------------
   always_comb begin
      en     = ctrl[spm_pkg::CTRL_EN];
      select_ignore_bit   = ctrl[spm_pkg::CTRL_SELECT_IGNORE_BIT];
      ord    = ctrl[spm_pkg::CTRL_ORD];
      master_select_bit   = ctrl[spm_pkg::CTRL_MASTER_SELECT_BIT];
      cpol   = ctrl[spm_pkg::CTRL_CPOL];
      cpha   = ctrl[spm_pkg::CTRL_CPHA];
      selout = cfg[spm_pkg::CFG_SELOUT];
      req    = psel & penable & ~pready;
      acc    = psel & penable & pready;
      wr     = acc & pwrite;
      wr_ctrl = wr & hit(paddr, spm_pkg::CTRL_IDX);
      wr_data = wr & hit(paddr, spm_pkg::DATA_IDX);
      wr_stat = wr & hit(paddr, spm_pkg::STAT_IDX);
      mapped  = hit(paddr, spm_pkg::STAT_IDX)
              | hit(paddr, spm_pkg::CTRL_IDX)
              | hit(paddr, spm_pkg::DATA_IDX)
              | hit(paddr, spm_pkg::CFG_IDX)
              | hit(paddr, spm_pkg::MASK_IDX);
      // one wait state: answer lands the cycle after the access phase opens
      next_pready  = req;
      next_pslverr = req & ~mapped;
      next_prdata  = 32'h0000_0000;
      if (req & ~pwrite) begin
         if (hit(paddr, spm_pkg::STAT_IDX)) begin
            next_prdata[spm_pkg::STAT_DONE] = done;
            next_prdata[spm_pkg::STAT_WRITE_COLLISION_FLAG] = write_collision_flag;
         end
         if (hit(paddr, spm_pkg::CTRL_IDX))
            next_prdata[7:0] = ctrl;
         if (hit(paddr, spm_pkg::DATA_IDX))
            next_prdata[7:0] = sh;
         if (hit(paddr, spm_pkg::CFG_IDX))
            next_prdata[2:0] = cfg;
         if (hit(paddr, spm_pkg::MASK_IDX)) begin
            next_prdata[spm_pkg::STAT_DONE] = mask[1];
            next_prdata[spm_pkg::STAT_WRITE_COLLISION_FLAG] = mask[0];
         end
      end
      next_cfg  = cfg;
      next_mask = mask;
      if (wr & hit(paddr, spm_pkg::CFG_IDX))
         next_cfg = pwdata[2:0];
      if (wr & hit(paddr, spm_pkg::MASK_IDX))
         next_mask = {pwdata[spm_pkg::STAT_DONE],
                      pwdata[spm_pkg::STAT_WRITE_COLLISION_FLAG]};
   end

   // ---------------- serial engine ----------------
   always_comb begin
      // select is live only when none of the ignore cases hold
      fault = en & master_select_bit & ~select_ignore_bit & ~selout & ~ss_n_i;
      is_master = en & master_select_bit & ~fault;
      slv_sel = en & ~master_select_bit & (select_ignore_bit | ~ss_n_i);
      busy = state == spm_pkg::ST_XFER;
      // master divider only runs inside a transfer
      tick = is_master & busy & (cnt == half_of(ctrl[1:0]) - 7'd1);
      m_lead  = tick & (sck_o == cpol);
      m_trail = tick & (sck_o != cpol);
      // slave sees one edge per core cycle at most, hence the rate ceiling
      s_edge = slv_sel & (sck_i != sck_prev);
      lead  = is_master ? m_lead : s_edge & (sck_i != cpol);
      trail = is_master ? m_trail : s_edge & (sck_i == cpol);
      samp  = cpha ? trail : lead;
      drv   = cpha ? lead : trail;
      inb   = is_master ? miso_i : mosi_i;
      edge_ev = lead | trail;

      next_state = state;
      next_ctrl  = ctrl;
      next_sh    = sh;
      next_cnt   = cnt;
      next_ecnt  = ecnt;
      next_dout  = dout;
      next_sck   = sck_o;
      next_done  = done;
      next_write_collision_flag  = write_collision_flag;

      if (wr_ctrl)
         next_ctrl = pwdata[7:0];
      if (wr_stat & pwdata[spm_pkg::STAT_DONE])
         next_done = 1'b0;
      if (wr_stat & pwdata[spm_pkg::STAT_WRITE_COLLISION_FLAG])
         next_write_collision_flag = 1'b0;

      if (is_master & busy)
         next_cnt = tick ? 7'd0 : cnt + 7'd1;
      if (tick)
         next_sck = ~sck_o;

      if (samp)
         next_sh = ord ? {inb, sh[7:1]} : {sh[6:0], inb};
      if (drv)
         next_dout = ord ? sh[0] : sh[7];

      unique case (state)
         spm_pkg::ST_IDLE: begin
            next_cnt  = 7'd0;
            next_ecnt = 4'd0;
            next_sck  = cpol;
            if (wr_data) begin
               next_sh = pwdata[7:0];
               if (is_master)
                  next_state = spm_pkg::ST_XFER;
            end
            if (s_edge & ~is_master) begin
               next_state = spm_pkg::ST_XFER;
               next_ecnt  = 4'd1;
            end
            // phase 0 presents the first bit before the first edge
            if (~cpha & ~edge_ev)
               next_dout = ord ? next_sh[0] : next_sh[7];
         end
         spm_pkg::ST_XFER: begin
            if (wr_data)
               next_write_collision_flag = 1'b1;
            if (edge_ev) begin
               next_ecnt = ecnt + 4'd1;
               if (ecnt == spm_pkg::LAST_EDGE) begin
                  next_state = spm_pkg::ST_IDLE;
                  next_done  = 1'b1;
                  next_sck   = cpol;
               end
            end
            // a dropped select or a disable abandons the word
            if (~en | (~is_master & ~slv_sel))
               next_state = spm_pkg::ST_IDLE;
         end
      endcase

      if (fault) begin
         next_ctrl[spm_pkg::CTRL_MASTER_SELECT_BIT] = 1'b0;
         next_done  = 1'b1;
         next_state = spm_pkg::ST_IDLE;
      end

      // pins are ordinary port pins while the port is off
      next_sck_oe  = is_master;
      next_mosi_oe = is_master;
      next_miso_oe = slv_sel & ~fault;
      next_ss_pin_port = ~en | select_ignore_bit | (master_select_bit & selout);
      // a set mask bit keeps its flag off the interrupt line
      next_irq = cfg[spm_pkg::CFG_PIE] & cfg[spm_pkg::CFG_GIE]
               & ((done & ~mask[1]) | (write_collision_flag & ~mask[0]));
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         ctrl        <= spm_pkg::CTRL_RST;
         cfg         <= spm_pkg::CFG_RST;
         mask        <= 2'h0;
         done        <= 1'b0;
         write_collision_flag        <= 1'b0;
         prdata      <= 32'h0000_0000;
         pready      <= 1'b0;
         pslverr     <= 1'b0;
         state       <= spm_pkg::ST_IDLE;
         sh          <= 8'h00;
         cnt         <= 7'h00;
         ecnt        <= 4'h0;
         dout        <= 1'b0;
         sck_prev    <= 1'b0;
         sck_o       <= 1'b0;
         sck_oe      <= 1'b0;
         mosi_oe     <= 1'b0;
         miso_oe     <= 1'b0;
         ss_pin_port <= 1'b1;
         irq         <= 1'b0;
      end else begin
         ctrl        <= next_ctrl;
         cfg         <= next_cfg;
         mask        <= next_mask;
         done        <= next_done;
         write_collision_flag        <= next_write_collision_flag;
         prdata      <= next_prdata;
         pready      <= next_pready;
         pslverr     <= next_pslverr;
         state       <= next_state;
         sh          <= next_sh;
         cnt         <= next_cnt;
         ecnt        <= next_ecnt;
         dout        <= next_dout;
         sck_prev    <= sck_i;
         sck_o       <= next_sck;
         sck_oe      <= next_sck_oe;
         mosi_oe     <= next_mosi_oe;
         miso_oe     <= next_miso_oe;
         ss_pin_port <= next_ss_pin_port;
         irq         <= next_irq;
      end
   end

   // both data pins carry the same shifted bit; the enables pick the pin
   assign mosi_o = dout;
   assign miso_o = dout;

   // ---------------- checks ----------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   a_write_collision_flag_busy_write: assert property (
      wr_data && busy |=> write_collision_flag)
      else $error("collision flag missed on busy data write");
   a_done_last_edge: assert property (
      busy && edge_ev && ecnt == 4'hF && !fault |=> done && !busy)
      else $error("transfer end did not raise done");
   a_fault_to_slave: assert property (
      fault && !wr_ctrl |=> !ctrl[spm_pkg::CTRL_MASTER_SELECT_BIT] && done)
      else $error("select low did not demote master");
   a_off_no_drive: assert property (
      !en |=> !sck_oe && !mosi_oe && !miso_oe)
      else $error("pin driven while port disabled");
   a_slave_sck_in: assert property (
      en && !master_select_bit |=> !sck_oe)
      else $error("slave drove the clock pin");
   a_sck_idle_level: assert property (
      !busy && $stable(ctrl) |=> sck_o == $past(cpol))
      else $error("serial clock not at idle level");
   a_half_period: assert property (
      busy && is_master && $changed(sck_o) && $stable(ctrl)
      |=> $stable(sck_o))
      else $error("master clock half period too short");
   a_ss_ignored: assert property (
      en && select_ignore_bit && master_select_bit && !ss_n_i && !wr_ctrl
      |=> ctrl[spm_pkg::CTRL_MASTER_SELECT_BIT])
      else $error("ignored select changed the role");
   a_irq_gated: assert property (
      irq |-> $past(cfg[spm_pkg::CFG_PIE]) && $past(cfg[spm_pkg::CFG_GIE]))
      else $error("interrupt raised without both enables");
   a_apb_answer: assert property (
      psel && penable && !pready |=> pready)
      else $error("bus access not answered in one wait state");
endmodule : spm_port

/* spm_far_end.sv */
// far-end serial slave device used against the port in master role
`timescale 1ns/1ps
module spm_far_end (
   input  wire logic       sck,
   input  wire logic       mosi,
   input  wire logic       sel_n,
   input  wire logic       cpol,
   input  wire logic       cpha,
   input  wire logic       lsb,
   input  wire logic [7:0] tx,
   output logic            miso,
   output logic      [7:0] rx
);
   int n = 0;
   function automatic logic pick(input int k);
      return lsb ? tx[k] : tx[7 - k];
   endfunction : pick
   initial begin
      miso = 1'b0;
      rx   = 8'h00;
   end
   always @(negedge sel_n) begin
      n = 0;
      if (!cpha) miso = pick(0);
   end
   // released line shows the inverse so a stale bit never passes
   always @(posedge sel_n) miso = ~miso;
   always @(sck) begin
      if (!sel_n && ((sck !== cpol) == cpha)) begin
         if (n < 8) miso = pick(n);
      end else if (!sel_n) begin
         rx = lsb ? {mosi, rx[7:1]} : {rx[6:0], mosi};
         n++;
      end
   end
endmodule : spm_far_end

/* tb.sv */
// self-checking bench for the serial peripheral port
`timescale 1ns/1ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin fails++; \
$display("[ERR] %s exp %0h got %0h", n, e, g); end end
module tb;
   localparam logic [11:0] A_ST = {spm_pkg::STAT_IDX, 2'b00};
   localparam logic [11:0] A_CT = {spm_pkg::CTRL_IDX, 2'b00};
   localparam logic [11:0] A_DT = {spm_pkg::DATA_IDX, 2'b00};
   localparam logic [11:0] A_CF = {spm_pkg::CFG_IDX, 2'b00};
   localparam logic [11:0] A_MK = {spm_pkg::MASK_IDX, 2'b00};
   localparam int DV [4] = '{spm_pkg::DIV_R0, spm_pkg::DIV_R1,
                             spm_pkg::DIV_R2, spm_pkg::DIV_R3};
   typedef struct packed {
      logic        w;
      logic [11:0] a;
      logic [7:0]  d;
      logic [7:0]  x;
      logic        e;
   } spm_row_t;
   localparam spm_row_t ROWS [9] = '{
      '{1'b0, A_CT, 8'h00, spm_pkg::CTRL_RST, 1'b0},
      '{1'b0, A_ST, 8'h00, 8'h00, 1'b0},
      '{1'b0, A_CF, 8'h00, 8'h00, 1'b0},
      '{1'b1, A_MK, 8'hC0, 8'h00, 1'b0},
      '{1'b0, A_MK, 8'h00, 8'hC0, 1'b0},
      '{1'b1, A_MK, 8'h00, 8'h00, 1'b0},
      '{1'b0, 12'h000, 8'h00, 8'h00, 1'b1},
      '{1'b1, 12'hFFC, 8'h5A, 8'h00, 1'b1},
      '{1'b0, A_CT, 8'h00, 8'h04, 1'b0}};
   logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0;
   logic pwrite = 1'b0, sck_tb = 1'b0, mosi_tb = 1'b0, ss_n = 1'b1;
   logic far_sel_n = 1'b1, cpol = 1'b0, cpha = 1'b0, lsb = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [7:0]  far_tx = 8'h00, far_rx, got, pat = 8'h3C;
   logic        pready, pslverr, er, irq, ss_pin_port, far_miso, sck_q;
   logic        sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe;
   int          fails = 0, num_checks = 0, cyc = 0, cnt = 0, hp = 0;
   wire sck_w  = sck_oe ? sck_o : sck_tb;
   wire mosi_w = mosi_oe ? mosi_o : mosi_tb;
   wire miso_w = miso_oe ? miso_o : far_miso;
   spm_port dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .sck_i(sck_w), .sck_o(sck_o),
      .sck_oe(sck_oe), .mosi_i(mosi_w), .mosi_o(mosi_o),
      .mosi_oe(mosi_oe), .miso_i(miso_w), .miso_o(miso_o),
      .miso_oe(miso_oe), .ss_n_i(ss_n), .ss_pin_port(ss_pin_port),
      .irq(irq));
   spm_far_end far (.sck(sck_w), .mosi(mosi_w), .sel_n(far_sel_n),
      .cpol(cpol), .cpha(cpha), .lsb(lsb), .tx(far_tx), .miso(far_miso),
      .rx(far_rx));
   initial begin
      forever #12.5 clk = ~clk;
   end
   task automatic end_of_test;
      if (fails == 0 && num_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : end_of_test
   // half-period monitor and hang guard
   always @(posedge clk) begin
      cyc   <= cyc + 1;
      sck_q <= sck_o;
      if (sck_o !== sck_q) begin
         hp  <= cnt;
         cnt <= 1;
      end else cnt <= cnt + 1;
      if (cyc == 20000) begin
         fails++;
         end_of_test();
      end
   end
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [7:0] d);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= {24'h0, d};
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask : apb
   task automatic chk_rd(input logic [11:0] a, input logic [7:0] x,
                         input string n);
      apb(1'b0, a, 8'h00);
      `CHK(n, {24'h0, x}, rd)
   endtask : chk_rd
   task automatic master(input logic [1:0] m, input logic [7:0] b);
      cpol   = m[0];
      cpha   = m[1];
      lsb    = ^m;
      far_tx = ~b;
      apb(1'b1, A_CT, {2'b11, lsb, 1'b1, cpol, cpha, m});
      // select only once the clock line has settled at its new idle level
      repeat (2) @(posedge clk);
      far_sel_n <= 1'b0;
      ss_n      <= 1'b0;
      `CHK("sck_oe", 1'b1, sck_oe)
      `CHK("mosi_oe", 1'b1, mosi_oe)
      `CHK("sck idle", cpol, sck_o)
      apb(1'b1, A_DT, b);
      if (m == 2'd0) apb(1'b1, A_DT, 8'h33);
      for (int i = 0; i < 800; i++) begin
         apb(1'b0, A_ST, 8'h00);
         if (rd[7] === 1'b1) break;
      end
      `CHK("far rx", b, far_rx)
      `CHK("half period", DV[m] / 2, hp)
      chk_rd(A_CT, {2'b11, lsb, 1'b1, cpol, cpha, m}, "sel ignored");
      chk_rd(A_ST, (m == 2'd0) ? 8'hC0 : 8'h80, "status");
      chk_rd(A_DT, ~b, "rx word");
      far_sel_n <= 1'b1;
      ss_n      <= 1'b1;
      apb(1'b1, A_ST, 8'hC0);
      chk_rd(A_ST, 8'h00, "flags clear");
   endtask : master
   initial begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      `CHK("sel pin reset", 1'b1, ss_pin_port)
      foreach (ROWS[i]) begin
         apb(ROWS[i].w, ROWS[i].a, ROWS[i].d);
         `CHK("pslverr", ROWS[i].e, er)
         if (!ROWS[i].w) `CHK("reg", {24'h0, ROWS[i].x}, rd)
      end
      ss_n <= 1'b0;
      apb(1'b1, A_CT, 8'h10);
      repeat (2) @(posedge clk);
      `CHK("sck_oe off", 1'b0, sck_oe)
      `CHK("miso_oe off", 1'b0, miso_oe)
      chk_rd(A_CT, 8'h10, "no fault off");
      ss_n <= 1'b1;
      for (int m = 0; m < 4; m++) master(m[1:0], 8'h96 + 8'(m));
      apb(1'b1, A_CF, 8'h06);
      apb(1'b1, A_CT, 8'h50);
      ss_n <= 1'b0;
      repeat (3) @(posedge clk);
      chk_rd(A_CT, 8'h40, "mode fault");
      chk_rd(A_ST, 8'h80, "fault done");
      `CHK("irq", 1'b1, irq)
      apb(1'b1, A_MK, 8'h80);
      repeat (2) @(posedge clk);
      `CHK("irq masked", 1'b0, irq)
      apb(1'b1, A_MK, 8'h00);
      apb(1'b1, A_CF, 8'h02);
      repeat (2) @(posedge clk);
      `CHK("irq gie off", 1'b0, irq)
      ss_n <= 1'b1;
      apb(1'b1, A_ST, 8'hC0);
      apb(1'b1, A_CF, 8'h01);
      apb(1'b1, A_CT, 8'h50);
      ss_n <= 1'b0;
      repeat (3) @(posedge clk);
      `CHK("sel pin free", 1'b1, ss_pin_port)
      chk_rd(A_CT, 8'h50, "still master");
      ss_n <= 1'b1;
      apb(1'b1, A_CT, 8'h44);
      apb(1'b1, A_DT, 8'hA5);
      ss_n <= 1'b0;
      for (int i = 7; i >= 0; i--) begin
         @(posedge clk);
         sck_tb  <= 1'b1;
         mosi_tb <= pat[i];
         repeat (spm_pkg::LINK_MIN_HALF) @(posedge clk);
         got[i] = miso_w;
         sck_tb <= 1'b0;
         repeat (spm_pkg::LINK_MIN_HALF - 1) @(posedge clk);
      end
      `CHK("miso_oe", 1'b1, miso_oe)
      `CHK("sck_oe slave", 1'b0, sck_oe)
      `CHK("slave tx", 8'hA5, got)
      chk_rd(A_DT, pat, "slave rx");
      ss_n <= 1'b1;
      chk_rd(A_ST, 8'h80, "slave done");
      `CHK("miso released", 1'b0, miso_oe)
      end_of_test();
   end
endmodule : tb
